// file: verilog/mqr_map.svh
// Register map, field positions, reset values and timing counts of the read port.
// Included by the read port only; definitions only.
`ifndef MQR_MAP_SVH
`define MQR_MAP_SVH
`define MQR_OFF_CTRL     8'h00
`define MQR_OFF_STATUS   8'h04
`define MQR_OFF_RDCOUNT  8'h08
`define MQR_CTRL_FALL_THROUGH_MODE    0
`define MQR_CTRL_EXPAND  1
`define MQR_CTRL_POLLED  2
`define MQR_CTRL_CFGRDY  3
`define MQR_CTRL_DEVID   4
`define MQR_CTRL_RESET   32'h0000_0001
`define MQR_ST_QSEL      0
`define MQR_ST_QUEUE     8
`define MQR_ST_SSEL      15
`define MQR_ST_SADDR     16
`define MQR_ST_QVALID    20
`define MQR_FALL_THROUGH_MODE_EDGES   2'h2
`endif

// file: verilog/mqr_pkg.sv
// Types used by the read port; the queue store needs none of them.
// Assumes the map header is compiled alongside.
package mqr_pkg;
  typedef enum logic [1:0] {MQR_BUS_IDLE, MQR_BUS_ACK} mqr_bus_e;
  typedef logic [7:0] mqr_addr_t;
endpackage : mqr_pkg

// file: verilog/mqr_store_if.sv
// Carrier between the read port and the queue store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface mqr_store_if #(
  parameter int NQ = 128,
  parameter int W  = 36
);
  logic                  rdEn;     // Pop one word
  logic [$clog2(NQ)-1:0] rdQueue;  // Queue being read
  logic [W-1:0]          rdData;   // Head word of rdQueue
  logic                  rdEmpty;  // rdQueue holds nothing
  modport port  (output rdEn, output rdQueue, input rdData, input rdEmpty);
  modport store (input rdEn, input rdQueue, output rdData, output rdEmpty);
endinterface : mqr_store_if
`default_nettype wire

// file: verilog/mqr_queue_store.sv
// Word storage for all queues with one read pointer and one write pointer each.
// Assumes the writer never pushes into a full queue; such pushes are dropped.
`timescale 1ns/1ps
`default_nettype none
module mqr_queue_store #(
  parameter int NQ    = 128,
  parameter int DEPTH = 256,
  parameter int W     = 36
) (
  input  wire logic                  core_clk,  // System clock
  input  wire logic                  rst_n,     // Async reset, active low
  input  wire logic                  clearAll,  // Master reset empties all
  input  wire logic                  wrEn,      // Push strobe
  input  wire logic [$clog2(NQ)-1:0] wrQueue,   // Queue to push
  input  wire logic [W-1:0]          wrData,    // Word to push
  mqr_store_if.store                 st         // Read side
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [NQ*DEPTH];
  logic [AW:0]  rdPtr [NQ];
  logic [AW:0]  wrPtr [NQ];
  logic         wrFull;

  // Head word and occupancy of the queue being read; full flag of the queue being written
  assign st.rdData  = mem[{st.rdQueue, rdPtr[st.rdQueue][AW-1:0]}];
  assign st.rdEmpty = rdPtr[st.rdQueue] == wrPtr[st.rdQueue];
  assign wrFull     = (wrPtr[wrQueue][AW-1:0] == rdPtr[wrQueue][AW-1:0])
                   && (wrPtr[wrQueue][AW] != rdPtr[wrQueue][AW]);

  // Storage array, written only
  always_ff @(posedge core_clk) begin
    if (wrEn && !wrFull) begin
      mem[{wrQueue, wrPtr[wrQueue][AW-1:0]}] <= wrData;
    end
  end

  // Pointer update per queue
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NQ; i++) begin
        rdPtr[i] <= '0;
        wrPtr[i] <= '0;
      end
    end else if (clearAll) begin
      for (int i = 0; i < NQ; i++) begin
        rdPtr[i] <= '0;
        wrPtr[i] <= '0;
      end
    end else begin
      if (st.rdEn && !st.rdEmpty) begin
        rdPtr[st.rdQueue] <= rdPtr[st.rdQueue] + 1'b1;
      end
      if (wrEn && !wrFull) begin
        wrPtr[wrQueue] <= wrPtr[wrQueue] + 1'b1;
      end
    end
  end
endmodule : mqr_queue_store
`default_nettype wire

// file: verilog/mqr_read_port.sv
// Read port of a multi-queue flow-control memory: queue and status selection.
// Assumes all pins synchronous to core_clk; a writer fills queues via wr*.
//
// What this block does
// - Output data driven only when chip select and output drive enable both allow.
// - Low seven address bits pick one of 128 queues.
// - In expansion, address bit seven must match bit zero of own id to respond.
// - Queue address latched on edge with read-address strobe high, flag-status strobe low and config done set.
// - The select edge may still output a word of the old queue.
// - Fall-through: new queue data on output at second edge after select.
// - In strobed flag mode, low four bits select the status word.
// - In expansion, during status selection, top three bits choose one of eight devices.
// - Address bit four is ignored during status selection.
// - Status address latched on edge with flag-status strobe high and read-address strobe low.
// - A queue read occurs only on edges with read strobe asserted, or on the fall-through load edge.
// - Fall-through queue selection works regardless of the read strobe.
// - Status cycling and status selection never need the read strobe.
// - Data leaves only with chip select low, drive enable low, queue selected.
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "mqr_map.svh"
module mqr_read_port import mqr_pkg::*; #(
  parameter int NQ    = 128,
  parameter int DEPTH = 256,
  parameter int W     = 36
) (
  input  wire logic                  core_clk,                 // 50 MHz clock
  input  wire logic                  rst_n,                    // Async reset
  input  wire logic                  master_reset_n,           // Master reset pin
  input  wire logic                  read_port_select_n,       // Read chip select
  input  wire logic                  read_enable_n,            // Read strobe
  input  wire logic                  out_enable_n,             // Output drive enable
  input  wire logic [7:0]            read_queue_addr,          // Read address bus
  input  wire logic                  read_addr_strobe,         // Queue select strobe
  input  wire logic                  flag_status_strobe,       // Status select strobe
  input  wire logic [NQ-1:0]         almost_empty_flags,       // Per-queue flags in
  input  wire logic [NQ-1:0]         packet_ready_flags,       // Per-queue flags in
  input  wire logic                  wrEn,                     // Fill strobe
  input  wire logic [$clog2(NQ)-1:0] wrQueue,                  // Fill queue
  input  wire logic [W-1:0]          wrData,                   // Fill word
  output logic [W-1:0]               qOut,                     // Output data
  output logic                       qOe,                      // Output data enable
  output logic [7:0]                 almost_empty_status_bus,  // Status word
  output logic [7:0]                 packet_ready_status_bus,  // Status word
  output logic                       statusOe,                 // Status bus enable
  output logic                       config_done_out,          // Low when ready
  input  wire logic [3:0]            avs_address,              // Word address
  input  wire logic                  avs_read,                 // Avalon read
  input  wire logic                  avs_write,                // Avalon write
  input  wire logic [31:0]           avs_writedata,            // Avalon write data
  input  wire logic [3:0]            avs_byteenable,           // Byte lanes
  output logic [31:0]                avs_readdata,             // Avalon read data
  output logic                       avs_waitrequest           // Avalon stall
);
  localparam int QW = $clog2(NQ);

  mqr_store_if #(.NQ(NQ), .W(W)) st ();

  logic [31:0] ctrl;
  logic [31:0] rdCount;
  mqr_bus_e    busState;
  logic [QW-1:0] selQueue;
  logic        qSelected;
  logic [3:0]  statAddr;
  logic        statSelected;
  logic [1:0]  fwftCnt;
  logic        qValid;
  logic        mrs;
  logic        rcsOk;
  logic        selAccept;
  logic        statAccept;
  logic        fwftLoad;
  logic        storeRd;
  logic [7:0]  byteAddr;
  logic [31:0] statusWord;
  logic [2:0]  devId;
  logic        cfgRdy;

  assign mrs      = !master_reset_n;
  assign devId    = ctrl[`MQR_CTRL_DEVID +: 3];
  assign cfgRdy   = ctrl[`MQR_CTRL_CFGRDY];
  assign byteAddr = {2'h0, avs_address, 2'h0};

  // Queue store holding the words of all queues
  mqr_queue_store #(.NQ(NQ), .DEPTH(DEPTH), .W(W)) u_store (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clearAll (mrs),
    .wrEn     (wrEn),
    .wrQueue  (wrQueue),
    .wrData   (wrData),
    .st       (st)
  );

  // chip select ignored during master reset
  assign rcsOk = !read_port_select_n && !mrs;

  // both strobes at once are dropped; queue select gated by config done
  assign selAccept  = read_addr_strobe && !flag_status_strobe && cfgRdy && !mrs;
  assign statAccept = flag_status_strobe && !read_addr_strobe && !mrs;

  // fall-through load on the second edge, without read strobe
  assign fwftLoad = ctrl[`MQR_CTRL_FALL_THROUGH_MODE] && (fwftCnt == 2'h1);

  // pop only with read strobe or fall-through load; needs chip select
  assign storeRd = rcsOk && qSelected && !st.rdEmpty && (fwftCnt != 2'h2)
                && (!read_enable_n || fwftLoad);
  assign st.rdEn    = storeRd;
  assign st.rdQueue = selQueue;

  // queue select latch; expansion match on bit seven
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      selQueue  <= '0;
      qSelected <= 1'b0;
    end else if (mrs) begin
      selQueue  <= '0;
      qSelected <= 1'b0;
    end else if (selAccept) begin
      selQueue  <= read_queue_addr[QW-1:0];
      qSelected <= !ctrl[`MQR_CTRL_EXPAND] || (read_queue_addr[7] == devId[0]);
    end
  end

  // fall-through countdown after a queue change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwftCnt <= 2'h0;
    end else if (mrs) begin
      fwftCnt <= 2'h0;
    end else if (selAccept && ctrl[`MQR_CTRL_FALL_THROUGH_MODE]) begin
      fwftCnt <= `MQR_FALL_THROUGH_MODE_EDGES;
    end else if (fwftCnt == 2'h2) begin
      fwftCnt <= 2'h1;
    end else if (fwftCnt == 2'h1 && (storeRd || !qSelected)) begin
      fwftCnt <= 2'h0;
    end
  end

  // output register takes the head word; old queue still on select edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      qOut   <= '0;
      qValid <= 1'b0;
    end else if (mrs) begin
      qValid <= 1'b0;
    end else if (storeRd) begin
      qOut   <= st.rdData;
      qValid <= 1'b1;
    end else if (selAccept && ctrl[`MQR_CTRL_FALL_THROUGH_MODE]) begin
      qValid <= 1'b0;
    end
  end

  // drive only when enabled and selected; chip select gates
  assign qOe = rcsOk && !out_enable_n && qSelected && qValid;

  // status word address; bit four unused
  // device pick on top bits; latched on strobe edge
  // polled mode cycles the word without read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      statAddr     <= 4'h0;
      statSelected <= 1'b0;
    end else if (mrs) begin
      statAddr     <= 4'h0;
      statSelected <= 1'b0;
    end else if (ctrl[`MQR_CTRL_POLLED]) begin
      statAddr     <= statAddr + 4'h1;
      statSelected <= 1'b1;
    end else if (statAccept) begin
      statAddr     <= read_queue_addr[3:0];
      statSelected <= !ctrl[`MQR_CTRL_EXPAND] || (read_queue_addr[7:5] == devId);
    end
  end

  // Status bus registers follow the selected word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      almost_empty_status_bus <= 8'hFF;
      packet_ready_status_bus <= 8'hFF;
      statusOe                <= 1'b0;
    end else begin
      almost_empty_status_bus <= almost_empty_flags[{statAddr, 3'h0} +: 8];
      packet_ready_status_bus <= packet_ready_flags[{statAddr, 3'h0} +: 8];
      statusOe                <= statSelected;
    end
  end

  // Configuration done output, low once software marks the part ready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_done_out <= 1'b1;
    end else begin
      config_done_out <= !cfgRdy;
    end
  end

  // Words delivered counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdCount <= 32'h0000_0000;
    end else if (storeRd) begin
      rdCount <= rdCount + 32'h0000_0001;
    end
  end

  // Avalon slave: one wait cycle, then answer
  assign avs_waitrequest = (avs_read || avs_write) && (busState == MQR_BUS_IDLE);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busState <= MQR_BUS_IDLE;
    end else if ((avs_read || avs_write) && busState == MQR_BUS_IDLE) begin
      busState <= MQR_BUS_ACK;
    end else begin
      busState <= MQR_BUS_IDLE;
    end
  end

  // Control register write with byte lanes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `MQR_CTRL_RESET;
    end else if (avs_write && !avs_waitrequest && byteAddr == `MQR_OFF_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          ctrl[b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
      end
    end
  end

  // Status word assembly
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`MQR_ST_QSEL]           = qSelected;
    statusWord[`MQR_ST_QUEUE +: QW]    = selQueue;
    statusWord[`MQR_ST_SSEL]           = statSelected;
    statusWord[`MQR_ST_SADDR +: 4]     = statAddr;
    statusWord[`MQR_ST_QVALID]         = qValid;
  end

  // Read data register; unmapped reads return zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && busState == MQR_BUS_IDLE) begin
      if (byteAddr == `MQR_OFF_CTRL) begin
        avs_readdata <= ctrl;
      end else if (byteAddr == `MQR_OFF_STATUS) begin
        avs_readdata <= statusWord;
      end else if (byteAddr == `MQR_OFF_RDCOUNT) begin
        avs_readdata <= rdCount;
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_out_gate: assert property (
    qOe |-> !read_port_select_n && !out_enable_n && qSelected && !mrs)
    else $error("output driven while not allowed");

  a_no_pop_idle: assert property (
    read_port_select_n |-> !st.rdEn)
    else $error("pointer moved without chip select");

  a_read_strobe: assert property (
    (storeRd && fwftCnt != 2'h1) |-> !read_enable_n)
    else $error("read without read strobe");

  a_queue_latch: assert property (
    (read_addr_strobe && !flag_status_strobe && cfgRdy && master_reset_n)
      |=> selQueue == $past(read_queue_addr[QW-1:0]))
    else $error("queue address not latched");

  a_exp_match: assert property (
    (selAccept && ctrl[`MQR_CTRL_EXPAND]) |=>
      qSelected == ($past(read_queue_addr[7]) == $past(devId[0])))
    else $error("expansion match wrong");

  a_fall_through_mode_second: assert property (
    (selAccept && ctrl[`MQR_CTRL_FALL_THROUGH_MODE]) |=> fwftCnt == 2'h2 ##1
      (fwftCnt == 2'h1 || selAccept || $past(mrs) || $past(selAccept)))
    else $error("fall-through count wrong");

  a_fall_through_mode_load: assert property (
    (fwftCnt == 2'h1 && ctrl[`MQR_CTRL_FALL_THROUGH_MODE] && rcsOk && qSelected && !st.rdEmpty)
      |=> qValid && qOut == $past(st.rdData))
    else $error("fall-through word not loaded");

  a_stat_latch: assert property (
    (statAccept && !ctrl[`MQR_CTRL_POLLED]) |=> statAddr == $past(read_queue_addr[3:0]))
    else $error("status address not latched");

  a_strobe_clash: assert property (
    (read_addr_strobe && flag_status_strobe && master_reset_n && !ctrl[`MQR_CTRL_POLLED])
      |=> $stable(selQueue) && $stable(statAddr))
    else $error("clashing strobes acted on");

  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  // Master reset silences the output and every pop
  a_mreset_quiet: assert property (
    mrs |-> !qOe && !st.rdEn)
    else $error("output or pop during master reset");

  // Store is read at the queue taken from the low address bits
  a_queue_index: assert property (
    selAccept |=> st.rdQueue == $past(read_queue_addr[QW-1:0]))
    else $error("queue index not taken from low bits");

  // A read on the select edge still delivers the old queue's word
  a_old_word: assert property (
    (selAccept && storeRd) |=> qValid && qOut == $past(st.rdData))
    else $error("old queue word lost on select edge");

  // Without a read on the select edge, no word is shown between a queue change and its fall-through load
  a_fall_through_mode_blank: assert property (
    (selAccept && ctrl[`MQR_CTRL_FALL_THROUGH_MODE] && !storeRd) |=> !qValid)
    else $error("stale word shown after queue change");

  // Expanded status selection compares the top three bits with the id
  a_stat_device: assert property (
    (statAccept && !ctrl[`MQR_CTRL_POLLED] && ctrl[`MQR_CTRL_EXPAND])
      |=> statSelected == ($past(read_queue_addr[7:5]) == $past(devId)))
    else $error("status device pick wrong");

  // Status selection never looks at address bit four
  a_bit_four: assert property (
    (statAccept && !ctrl[`MQR_CTRL_POLLED]) |=> statSelected ==
      (!$past(ctrl[`MQR_CTRL_EXPAND]) || ($past(read_queue_addr[7:5]) == $past(devId))))
    else $error("status selection depends on bit four");

  // Polled mode steps the status word on every edge without read strobe
  a_polled_step: assert property (
    (ctrl[`MQR_CTRL_POLLED] && !mrs) |=> statAddr == $past(statAddr) + 4'h1)
    else $error("polled status word did not advance");
endmodule : mqr_read_port
`default_nettype wire

// file: testbench/mqr_host_model.sv
// Host controller model: drives the read address bus and both select strobes.
// Assumes one core_clk shared with the read port; tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none
module mqr_host_model (
  input  wire logic       core_clk,            // Shared clock
  input  wire logic       config_done_out,     // Low once the device is ready
  output var  logic [7:0] read_queue_addr,     // Address bus to the device
  output var  logic       read_addr_strobe,    // Queue select strobe
  output var  logic       flag_status_strobe   // Status select strobe
);
  initial begin
    read_queue_addr    = 8'h00;
    read_addr_strobe   = 1'b0;
    flag_status_strobe = 1'b0;
  end

  // One-cycle strobe; the idle bus shows the inverse so stale values never pass
  // single strobe, never held
  task automatic pulse(input logic isQueue, input logic [7:0] addr);
    @(posedge core_clk);
    read_queue_addr    <= addr;
    read_addr_strobe   <= isQueue;
    flag_status_strobe <= !isQueue;
    @(posedge core_clk);
    read_addr_strobe   <= 1'b0;
    flag_status_strobe <= 1'b0;
    read_queue_addr    <= ~addr;
  endtask : pulse

  // Queue change only after the device reports ready
  // wait for ready
  task automatic select_queue(input logic [7:0] addr);
    while (config_done_out !== 1'b0) @(posedge core_clk);
    pulse(1'b1, addr);
  endtask : select_queue

  // Status word choice needs no read strobe
  task automatic select_status(input logic [7:0] addr);
    pulse(1'b0, addr);
  endtask : select_status
endmodule : mqr_host_model
`default_nettype wire

// file: testbench/multi_queue_read_port_select_test.sv
// Self-checking bench for the read port: registers, queue and status selection.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module multi_queue_read_port_select_test;
  import mqr_pkg::*;
  logic coreClk, rstN, mrN, selN, renN, oeN, wrEn, avsRead, avsWrite;
  logic [127:0] aeFlags, prFlags;
  logic [6:0] wrQueue;
  logic [35:0] wrData, qOut;
  logic qOe, statusOe, cfgDone, raStb, fsStb, avsWait;
  logic [7:0] addr, aeBus, prBus;
  logic [3:0] avsAddr, avsBe;
  logic [31:0] avsWdata, avsRdata, rd;
  int num_errors, samples_checked, cycles;

  initial begin
    coreClk = 1'b0;
    forever #10 coreClk = ~coreClk;
  end

  mqr_host_model host (.core_clk(coreClk), .config_done_out(cfgDone),
    .read_queue_addr(addr), .read_addr_strobe(raStb), .flag_status_strobe(fsStb));

  mqr_read_port #(.NQ(128), .DEPTH(4), .W(36)) DUT (
    .core_clk(coreClk), .rst_n(rstN), .master_reset_n(mrN),
    .read_port_select_n(selN), .read_enable_n(renN), .out_enable_n(oeN),
    .read_queue_addr(addr), .read_addr_strobe(raStb), .flag_status_strobe(fsStb),
    .almost_empty_flags(aeFlags), .packet_ready_flags(prFlags),
    .wrEn(wrEn), .wrQueue(wrQueue), .wrData(wrData), .qOut(qOut), .qOe(qOe),
    .almost_empty_status_bus(aeBus), .packet_ready_status_bus(prBus),
    .statusOe(statusOe), .config_done_out(cfgDone), .avs_address(avsAddr),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
    .avs_byteenable(avsBe), .avs_readdata(avsRdata), .avs_waitrequest(avsWait));

  // Compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] expected,
                       input string what);
    samples_checked++;
    if (seen !== expected) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, expected);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Avalon access held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge coreClk);
    avsAddr  <= a;
    avsWdata <= d;
    avsRead  <= !wr;
    avsWrite <= wr;
    do @(posedge coreClk); while (avsWait !== 1'b0);
    rd = avsRdata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus

  task automatic fill(input logic [6:0] q, input logic [35:0] d);
    @(posedge coreClk);
    wrEn    <= 1'b1;
    wrQueue <= q;
    wrData  <= d;
    @(posedge coreClk);
    wrEn <= 1'b0;
  endtask : fill

  task automatic pop(input logic cs);
    @(posedge coreClk);
    selN <= cs;
    renN <= 1'b0;
    #1 if (cs) check(qOe, 1'b0, "bus undriven");
    @(posedge coreClk);
    renN <= 1'b1;
    selN <= 1'b0;
    #1;
  endtask : pop

  task automatic t_regs;
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0000_0001, "ctrl reset");
    check(cfgDone, 1'b1, "not ready");
    bus(1'b0, 4'h3, 32'h0);
    check(rd, 32'h0, "unmapped read");
    bus(1'b1, 4'h0, 32'h0000_0009);
    avsBe <= 4'hE;
    bus(1'b1, 4'h0, 32'h0000_0000);
    avsBe <= 4'hF;
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0000_0009, "masked lane kept");
    #1 check(cfgDone, 1'b0, "ready low");
    $display("test regs done");
  endtask : t_regs

  task automatic t_fall_through_mode;
    fill(7'h05, 36'hA_0000_0001);
    fill(7'h05, 36'hA_0000_0002);
    fill(7'h05, 36'hA_0000_0003);
    fill(7'h06, 36'hB_0000_0001);
    host.select_queue(8'h05);
    @(posedge coreClk);
    #1 check(qOe, 1'b0, "no word yet");
    @(posedge coreClk);
    #1 check(qOut, 36'hA_0000_0001, "fall-through head");
    check(qOe, 1'b1, "output driven");
    @(posedge coreClk);
    oeN <= 1'b1;
    #1 check(qOe, 1'b0, "drive enable off");
    @(posedge coreClk);
    oeN <= 1'b0;
    pop(1'b1);
    check(qOut, 36'hA_0000_0001, "blocked pop");
    pop(1'b0);
    check(qOut, 36'hA_0000_0002, "strobed pop");
    $display("test fall_through_mode done");
  endtask : t_fall_through_mode

  // Queue change with a read on the very same edge
  task automatic t_switch;
    fork
      host.select_queue(8'h06);
      pop(1'b0);
    join
    check(qOut, 36'hA_0000_0003, "old queue on select edge");
    @(posedge coreClk);
    @(posedge coreClk);
    #1 check(qOut, 36'hB_0000_0001, "new queue head");
    bus(1'b0, 4'h1, 32'h0);
    check(rd[14:0], 15'h0601, "queue selected");
    $display("test switch done");
  endtask : t_switch

  task automatic t_status;
    host.select_status(8'h13);
    @(posedge coreClk);
    #1 check(aeBus, aeFlags[31:24], "ae word");
    check(prBus, prFlags[31:24], "pr word");
    check(statusOe, 1'b1, "status on");
    bus(1'b1, 4'h0, 32'h0000_002B);
    host.select_status(8'h63);
    @(posedge coreClk);
    #1 check(statusOe, 1'b0, "other device");
    host.select_status(8'h45);
    @(posedge coreClk);
    #1 check(aeBus, aeFlags[47:40], "own device");
    host.select_queue(8'h85);
    bus(1'b0, 4'h1, 32'h0);
    check(rd[0], 1'b0, "foreign queue");
    host.select_queue(8'h05);
    bus(1'b0, 4'h1, 32'h0);
    check(rd[14:0], 15'h0501, "own queue");
    bus(1'b1, 4'h0, 32'h0000_000D);
    @(posedge coreClk);
    @(posedge coreClk);
    #1 check(aeBus, aeFlags[55:48], "polled word");
    @(posedge coreClk);
    #1 check(aeBus, aeFlags[63:56], "polled next");
    $display("test status done");
  endtask : t_status

  task automatic t_mreset;
    fill(7'h05, 36'hC_0000_0001);
    @(posedge coreClk);
    #1 check(qOut, 36'hC_0000_0001, "late fall-through");
    check(qOe, 1'b1, "late word driven");
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0000_0005, "words popped");
    @(posedge coreClk);
    mrN  <= 1'b0;
    renN <= 1'b0;
    #1 check(qOe, 1'b0, "chip select ignored in master reset");
    @(posedge coreClk);
    mrN  <= 1'b1;
    renN <= 1'b1;
    #1 check(qOe, 1'b0, "word dropped by master reset");
    bus(1'b0, 4'h1, 32'h0);
    check(rd[0], 1'b0, "selection cleared");
    $display("test master reset done");
  endtask : t_mreset

  // Hang guard
  always @(posedge coreClk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    {rstN, selN, oeN, wrEn, avsRead, avsWrite} = 6'h00;
    {mrN, renN} = 2'h3;
    aeFlags = 128'h0F0E0D0C_0B0A0908_07060504_03020100;
    avsBe = 4'hF;
    prFlags = {16{8'h3C}} ^ {16{8'hF0}} << 24;
    {wrQueue, wrData, avsAddr, avsWdata} = '0;
    repeat (8) @(posedge coreClk);
    rstN <= 1'b1;
    t_regs();
    t_fall_through_mode();
    t_switch();
    t_status();
    t_mreset();
    close_out();
  end
endmodule : multi_queue_read_port_select_test
`default_nettype wire
